// ### bench/dmdm_master.sv
// Serial master model: sends request frames byte by byte and collects the answer.
// Assumes the interpreter runs on the same clock and takes one byte per pulse.
`timescale 1ns/1ns
module dmdm_master (
   input wire logic ref_clk_in,
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic tx_ready_out,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in
);
   logic [7:0] got_q[$];
   logic [15:0] lfsr = 16'hACE1;

   initial
   begin
      rx_valid_out = 1'b0;
      rx_data_out = 8'h00;
      tx_ready_out = 1'b0;
   end

   // --------------------------------
   // Answer side, stalls on a pattern
   // --------------------------------
   always @(posedge ref_clk_in)
   begin
      if (tx_valid_in === 1'b1 && tx_ready_out)
         got_q.push_back(tx_data_in);
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      tx_ready_out <= lfsr[0] | lfsr[3];
   end

   // Spacing stays well under the frame gap so bytes join one frame
   task automatic send(input logic [7:0] q[$]);
      foreach (q[i])
      begin
         @(posedge ref_clk_in);
         rx_valid_out <= 1'b1;
         rx_data_out <= q[i];
         @(posedge ref_clk_in);
         rx_valid_out <= 1'b0;
         rx_data_out <= ~q[i];
         repeat (lfsr[1:0]) @(posedge ref_clk_in);
      end
   endtask

   // Bounded wait; a short answer is left for the caller to judge
   task automatic recv(input int n, output logic [7:0] r[$]);
      int k;
      k = 0;
      while (got_q.size() < n && k < 3000)
      begin
         @(posedge ref_clk_in);
         k++;
      end
      repeat (6) @(posedge ref_clk_in);
      r = got_q;
      got_q.delete();
   endtask
endmodule

// ### bench/drive_modbus_data_map_tb.sv
// Self-checking bench for the drive data-map interpreter.
// Assumes the master model in dmdm_master.sv and a shortened frame gap.
`timescale 1ns/1ns
module drive_modbus_data_map_tb;
   localparam logic [7:0] SLV = 8'h02;
   logic ref_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic rx_valid, tx_ready, tx_valid, cmd_valid;
   logic [7:0] rx_data, tx_data;
   logic [2:0] stat = 3'h0;
   logic [15:0] fcode = 16'h0000;
   logic [15:0] fmax = 16'h0000;
   logic [15:0] freq, target, val;
   logic [3:0] cmd;
   logic [3:0] cmds[6] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8};
   logic [31:0] seed = 32'h0000000D;
   logic [7:0] rsp[$];
   int err_count = 0;
   int num_checks = 0;
   int pulses = 0;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("Error at %0t ns: got %0h expected %0h", $time, g, e); end end

   dmdm_data_map #(.GAP_CYCLES(20)) u_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .ce_in(1'b1), .slave_addr_in(SLV), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
      .tx_ready_in(tx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
      .fwd_running_in(stat[0]), .rev_running_in(stat[1]), .fault_active_in(stat[2]),
      .fault_code_in(fcode), .max_frequency_setting_in(fmax), .freq_ref_out(freq),
      .target_freq_out(target), .drive_cmd_out(cmd), .drive_cmd_valid_out(cmd_valid));
   dmdm_master u_master (.ref_clk_in(ref_clk_in), .rx_valid_out(rx_valid),
      .rx_data_out(rx_data), .tx_ready_out(tx_ready), .tx_valid_in(tx_valid),
      .tx_data_in(tx_data));

   initial
   begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in)
   begin
      if (cmd_valid === 1'b1)
         pulses++;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i])
      begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Kind 0 echo, 1 exception code, 2 one read word, 3 bad check bytes
   // ------------------------------------------------------------
   task automatic xact(input logic [7:0] fn, input logic [15:0] a, input logic [15:0] v,
      input int kind, input logic [15:0] e);
      logic [7:0] rq[$];
      logic [7:0] ex[$];
      logic [15:0] c;
      rq = {SLV, fn, a[15:8], a[7:0], v[15:8], v[7:0]};
      if (kind == 0)
         ex = rq;
      else if (kind == 1)
         ex = {SLV, fn | 8'h80, e[7:0]};
      else
         ex = {SLV, fn, 8'h02, e[15:8], e[7:0]};
      c = crc(rq);
      // Kind 3 spoils the check bytes; such a frame must go unanswered
      rq = {rq, c[7:0], c[15:8] ^ ((kind == 3) ? 8'h01 : 8'h00)};
      c = crc(ex);
      ex = {ex, c[7:0], c[15:8]};
      if (kind == 3)
         ex.delete();
      u_master.send(rq);
      u_master.recv((kind == 3) ? 1 : ex.size(), rsp);
      `CHK(rsp.size(), ex.size())
      if (rsp.size() != ex.size())
         tally_and_finish();
      foreach (ex[i]) `CHK(rsp[i], ex[i])
      $display("Test done: function %0h address %0h", fn, a);
   endtask

   initial
   begin
      repeat (4) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      fmax <= 16'(rnd());
      xact(8'h06, 16'h1000, 16'h2710, 0, 16'h0000);
      `CHK(target, fmax)
      val = 16'(rnd() % 32'h00002711);
      xact(8'h06, 16'h1000, val, 0, 16'h0000);
      `CHK(target, 16'((32'(val) * 32'(fmax)) / 32'h00002710))
      xact(8'h06, 16'h1000, 16'h2711, 1, 16'h0003);
      `CHK(freq, val)
      xact(8'h06, 16'h1000, 16'h0005, 3, 16'h0000);
      `CHK(freq, val)
      foreach (cmds[i])
      begin
         xact(8'h06, 16'h2000, {12'h000, cmds[i]}, 0, 16'h0000);
         `CHK(cmd, cmds[i])
      end
      xact(8'h06, 16'h2000, 16'h0003, 1, 16'h0003);
      `CHK(pulses, 6)
      @(posedge ref_clk_in);
      stat <= 3'(rnd());
      fcode <= 16'(rnd());
      @(posedge ref_clk_in);
      xact(8'h03, 16'h3000, 16'h0001, 2, {13'h0000, stat});
      xact(8'h03, 16'h8000, 16'h0001, 2, fcode);
      xact(8'h10, 16'hF000, 16'h0001, 1, 16'h0001);
      xact(8'h03, 16'hF00A, 16'h0000, 1, 16'h0003);
      xact(8'h06, 16'h3000, 16'h0000, 1, 16'h0002);
      xact(8'h03, 16'h2000, 16'h0001, 1, 16'h0002);
      xact(8'h06, 16'hD005, 16'h0001, 1, 16'h0002);
      xact(8'h06, 16'hAF01, 16'h0001, 1, 16'h0002);
      @(posedge ref_clk_in);
      stat <= 3'h1;
      xact(8'h06, 16'hB105, 16'h0001, 1, 16'h0004);
      @(posedge ref_clk_in);
      stat <= 3'h0;
      val = 16'(rnd());
      xact(8'h06, 16'hF00A, val, 0, 16'h0000);
      xact(8'h03, 16'hF00A, 16'h0001, 2, val);
      tally_and_finish();
   end
endmodule

// ### rtl/dmdm_data_map.sv
// Serial-slave command interpreter: frames, checks and answers read/write requests.
// Assumes a same-clock byte receiver and a byte transmitter with a ready handshake.
`timescale 1ns/1ns

// Operation
// - Address: group high byte, index low byte
// - Refuse locked, factory and monitor parameter writes
// - Frequency reference 0..10000 is full-scale fraction
// - Run word write-only, each write acted on
// - Decode run values 1,2,5,6,7,8
// - Status word: fwd, rev, fault bits
// - Read-only word returns active fault code
// - Exception frame: address, function+0x80, code, CRC
// - Codes: function 1, address 2, data 3, busy 4
// - Function 03 reads, 06 writes one
// - Frames delimited by 3.5 character silence
// - CRC-16 from all ones, low byte first
// - Successful write answered by echoing the request
module dmdm_data_map #(
   parameter int GAP_CYCLES = dmdm_pkg::FRAME_GAP_CYCLES,
   parameter int MAX_READ = dmdm_pkg::MAX_READ_WORDS,
   parameter int RAM_AW = 12
)(
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic [7:0] slave_addr_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic tx_ready_in,
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   input wire logic fwd_running_in,
   input wire logic rev_running_in,
   input wire logic fault_active_in,
   input wire logic [15:0] fault_code_in,
   input wire logic [15:0] max_frequency_setting_in,
   output logic [15:0] freq_ref_out,
   output logic [15:0] target_freq_out,
   output logic [3:0] drive_cmd_out,
   output logic drive_cmd_valid_out
);

   localparam int GAP_W = $clog2(GAP_CYCLES + 1);
   localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(GAP_CYCLES);
   localparam logic [15:0] READ_LIMIT = 16'(MAX_READ);

   dmdm_pkg::dmdm_state_e state;
   dmdm_pkg::dmdm_rsp_e rsp;
   logic [7:0] rx_buf [0:dmdm_pkg::FRAME_BUF_BYTES-1];
   logic [7:0] rx_cnt;
   logic [15:0] rx_crc;
   logic [GAP_W-1:0] gap_cnt;
   logic [7:0] tx_len;
   logic [7:0] tx_k;
   logic [15:0] tx_crc;
   logic [15:0] rd_ptr;
   logic [7:0] exc_q;
   logic [15:0] ram_rd_data;

   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   wire [7:0] func = rx_buf[1];
   wire [7:0] grp = rx_buf[2];
   wire [7:0] idx = rx_buf[3];
   wire [15:0] reg_addr = {rx_buf[2], rx_buf[3]};
   wire [15:0] reg_val = {rx_buf[4], rx_buf[5]};
   wire running = fwd_running_in | rev_running_in;
   wire [7:0] next_rx_cnt = rx_cnt + 8'h01;
   wire is_broadcast = rx_buf[0] == 8'h00;
   // A good frame leaves a zero residue when its own CRC is folded in
   wire frame_ok = (rx_buf[0] == slave_addr_in || is_broadcast) &&
                   rx_crc == 16'h0000 && rx_cnt >= 8'h04;
   wire frame_end = state == dmdm_pkg::ST_RX && rx_cnt != 8'h00 &&
                    gap_cnt == GAP_LIMIT && !rx_valid_in;
   wire is_read = func == dmdm_pkg::FUNC_READ;
   wire is_write = func == dmdm_pkg::FUNC_WRITE;
   wire len_ok = rx_cnt == 8'(dmdm_pkg::FRAME_BUF_BYTES);
   wire [16:0] rd_span = {9'h000, idx} + {1'b0, reg_val};
   wire rd_count_ok = reg_val != 16'h0000 && reg_val <= READ_LIMIT;
   wire rd_special = reg_val == 16'h0001 &&
                     (reg_addr == dmdm_pkg::ADDR_STATUS || reg_addr == dmdm_pkg::ADDR_FAULT);
   // A read range must stay inside one group
   wire rd_addr_ok = rd_special ||
                     (dmdm_pkg::is_param_group(grp) && rd_span <= 17'h00100);
   wire wr_freq = reg_addr == dmdm_pkg::ADDR_FREQ_REF;
   wire wr_cmd = reg_addr == dmdm_pkg::ADDR_RUN_CMD;
   wire wr_param = dmdm_pkg::is_param_group(grp);
   wire cmd_ok = reg_val == dmdm_pkg::CMD_FWD_RUN || reg_val == dmdm_pkg::CMD_REV_RUN ||
                 reg_val == dmdm_pkg::CMD_COAST_STOP || reg_val == dmdm_pkg::CMD_DECEL_STOP ||
                 reg_val == dmdm_pkg::CMD_FAULT_RESET ||
                 reg_val == dmdm_pkg::CMD_QUICK_STOP;
   wire wr_protected = grp == dmdm_pkg::MONITOR_GROUP_FIRST ||
                       grp == dmdm_pkg::MONITOR_GROUP_SECOND ||
                       grp == dmdm_pkg::FACTORY_GROUP;
   wire wr_locked = grp[7:4] == dmdm_pkg::RUN_LOCKED_FAMILY && running;
   wire [7:0] wr_exc = wr_freq ? (reg_val > dmdm_pkg::FREQ_FULL_SCALE ?
                                  dmdm_pkg::EXC_DATA : dmdm_pkg::EXC_NONE) :
                       wr_cmd ? (cmd_ok ? dmdm_pkg::EXC_NONE : dmdm_pkg::EXC_DATA) :
                       !wr_param ? dmdm_pkg::EXC_ADDR :
                       wr_protected ? dmdm_pkg::EXC_ADDR :
                       wr_locked ? dmdm_pkg::EXC_BUSY : dmdm_pkg::EXC_NONE;
   wire [7:0] rd_exc = !rd_count_ok ? dmdm_pkg::EXC_DATA :
                       !rd_addr_ok ? dmdm_pkg::EXC_ADDR : dmdm_pkg::EXC_NONE;
   wire [7:0] exc_code = (!is_read && !is_write) ? dmdm_pkg::EXC_FUNC :
                         !len_ok ? dmdm_pkg::EXC_DATA :
                         is_read ? rd_exc : wr_exc;
   wire write_go = state == dmdm_pkg::ST_EXEC && frame_ok && is_write &&
                   exc_code == dmdm_pkg::EXC_NONE;
   wire ram_wr = ce_in && write_go && wr_param;

   // ----------------------------------------
   // Answer byte selection
   // ----------------------------------------
   wire [15:0] status_word = {13'h0000, fault_active_in, rev_running_in,
                              fwd_running_in};
   wire [15:0] rd_word = rd_ptr == dmdm_pkg::ADDR_STATUS ? status_word :
                         rd_ptr == dmdm_pkg::ADDR_FAULT ? fault_code_in :
                         ram_rd_data;
   wire [7:0] k_data = tx_k - 8'h03;
   wire [7:0] byte_count = {reg_val[6:0], 1'b0};
   wire [7:0] exc_byte = tx_k == 8'h00 ? rx_buf[0] :
                         tx_k == 8'h01 ? (func | dmdm_pkg::FUNC_EXC_FLAG) : exc_q;
   wire [7:0] read_byte = tx_k == 8'h00 ? rx_buf[0] :
                          tx_k == 8'h01 ? func :
                          tx_k == 8'h02 ? byte_count :
                          k_data[0] ? rd_word[7:0] : rd_word[15:8];
   wire [7:0] payload = rsp == dmdm_pkg::RSP_ECHO ? rx_buf[tx_k[2:0]] :
                        rsp == dmdm_pkg::RSP_EXC ? exc_byte : read_byte;
   wire [7:0] next_tx_byte = tx_k < tx_len ? payload :
                             tx_k == tx_len ? tx_crc[7:0] : tx_crc[15:8];
   wire [7:0] next_k = tx_k + 8'h01;
   wire [7:0] next_k_data = next_k - 8'h03;
   wire fetch_next = rsp == dmdm_pkg::RSP_READ && next_k >= 8'h03 &&
                     next_k < tx_len && !next_k_data[0];
   wire low_word_sent = rsp == dmdm_pkg::RSP_READ && tx_k >= 8'h03 &&
                        tx_k < tx_len && k_data[0];
   wire [RAM_AW-1:0] ram_addr = state == dmdm_pkg::ST_FETCH ? rd_ptr[RAM_AW-1:0] :
                                reg_addr[RAM_AW-1:0];
   wire [31:0] freq_product = {16'h0000, freq_ref_out} * {16'h0000, max_frequency_setting_in};
   wire [31:0] freq_scaled = freq_product / {16'h0000, dmdm_pkg::FREQ_FULL_SCALE};

   assign tx_valid_out = state == dmdm_pkg::ST_SEND;

   dmdm_param_ram #(.AW(RAM_AW), .DW(16)) u_param_ram (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .ce_in(ce_in),
      .wr_en_in(ram_wr),
      .rd_en_in(state == dmdm_pkg::ST_FETCH),
      .addr_in(ram_addr),
      .wr_data_in(reg_val),
      .rd_data_out(ram_rd_data)
   );

   // ----------------------------------------
   // Frame reception
   // ----------------------------------------
   // Bytes closer than the gap extend the current frame; those during an answer are dropped
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rx_cnt <= 8'h00;
         rx_crc <= dmdm_pkg::CRC_INIT;
         gap_cnt <= '0;
      end
      else if (ce_in)
      begin
         if (state != dmdm_pkg::ST_RX)
         begin
            rx_cnt <= 8'h00;
            rx_crc <= dmdm_pkg::CRC_INIT;
            gap_cnt <= '0;
         end
         else if (rx_valid_in)
         begin
            if (rx_cnt != 8'hFF)
               rx_cnt <= next_rx_cnt;
            rx_crc <= dmdm_pkg::crc16_byte(rx_crc, rx_data_in);
            gap_cnt <= '0;
         end
         else if (gap_cnt != GAP_LIMIT)
            gap_cnt <= gap_cnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         for (int i = 0; i < dmdm_pkg::FRAME_BUF_BYTES; i++)
            rx_buf[i] <= 8'h00;
      end
      else if (ce_in && state == dmdm_pkg::ST_RX && rx_valid_in &&
               rx_cnt < 8'(dmdm_pkg::FRAME_BUF_BYTES))
         rx_buf[rx_cnt[2:0]] <= rx_data_in;
   end

   // ----------------------------------------
   // Execution and answer sequencing
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state <= dmdm_pkg::ST_RX;
         rsp <= dmdm_pkg::RSP_ECHO;
         tx_len <= 8'h00;
         tx_k <= 8'h00;
         tx_crc <= dmdm_pkg::CRC_INIT;
         tx_data_out <= 8'h00;
         rd_ptr <= 16'h0000;
         exc_q <= dmdm_pkg::EXC_NONE;
      end
      else if (ce_in)
      begin
         case (state)
            dmdm_pkg::ST_RX:
               if (frame_end)
                  state <= dmdm_pkg::ST_EXEC;
            dmdm_pkg::ST_EXEC:
            begin
               tx_k <= 8'h00;
               tx_crc <= dmdm_pkg::CRC_INIT;
               rd_ptr <= reg_addr;
               exc_q <= exc_code;
               // Broadcast requests are carried out but never answered
               if (!frame_ok || is_broadcast)
                  state <= dmdm_pkg::ST_RX;
               else
                  state <= dmdm_pkg::ST_PREP;
               if (exc_code != dmdm_pkg::EXC_NONE)
               begin
                  rsp <= dmdm_pkg::RSP_EXC;
                  tx_len <= 8'h03;
               end
               else if (is_read)
               begin
                  rsp <= dmdm_pkg::RSP_READ;
                  tx_len <= 8'h03 + byte_count;
               end
               else
               begin
                  rsp <= dmdm_pkg::RSP_ECHO;
                  tx_len <= 8'h06;
               end
            end
            dmdm_pkg::ST_FETCH:
               state <= dmdm_pkg::ST_PREP;
            dmdm_pkg::ST_PREP:
            begin
               tx_data_out <= next_tx_byte;
               state <= dmdm_pkg::ST_SEND;
            end
            dmdm_pkg::ST_SEND:
               if (tx_ready_in)
               begin
                  if (tx_k < tx_len)
                     tx_crc <= dmdm_pkg::crc16_byte(tx_crc, tx_data_out);
                  if (low_word_sent)
                     rd_ptr <= rd_ptr + 16'h0001;
                  tx_k <= next_k;
                  if (tx_k == tx_len + 8'h01)
                     state <= dmdm_pkg::ST_RX;
                  else if (fetch_next)
                     state <= dmdm_pkg::ST_FETCH;
                  else
                     state <= dmdm_pkg::ST_PREP;
               end
            default:
               state <= dmdm_pkg::ST_RX;
         endcase
      end
   end

   // ----------------------------------------
   // Drive-facing words
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         freq_ref_out <= 16'h0000;
         target_freq_out <= 16'h0000;
         drive_cmd_out <= 4'h0;
         drive_cmd_valid_out <= 1'b0;
      end
      else if (ce_in)
      begin
         if (write_go && wr_freq)
            freq_ref_out <= reg_val;
         target_freq_out <= freq_scaled[15:0];
         drive_cmd_valid_out <= write_go && wr_cmd;
         if (write_go && wr_cmd)
            drive_cmd_out <= reg_val[3:0];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking dmdm_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence seq_exec_taken;
      state == dmdm_pkg::ST_EXEC && ce_in && frame_ok && !is_broadcast;
   endsequence

   sequence seq_exc_func_byte;
      state == dmdm_pkg::ST_PREP && ce_in && rsp == dmdm_pkg::RSP_EXC && tx_k == 8'h01;
   endsequence

   a_gap_holds_frame: assert property (
      state == dmdm_pkg::ST_RX && ce_in && (rx_valid_in || gap_cnt != GAP_LIMIT)
      |=> state == dmdm_pkg::ST_RX)
      else $error("frame closed before the silent gap");

   a_freq_range: assert property (
      $changed(freq_ref_out) |-> freq_ref_out <= dmdm_pkg::FREQ_FULL_SCALE)
      else $error("frequency reference above full scale");

   a_cmd_decode: assert property (
      drive_cmd_valid_out |-> drive_cmd_out inside {4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8})
      else $error("undefined run command issued");

   a_cmd_pulse: assert property (
      drive_cmd_valid_out && ce_in |=> !drive_cmd_valid_out)
      else $error("run command pulse longer than one cycle");

   a_protect_write: assert property (
      ram_wr |-> !wr_protected && !wr_locked)
      else $error("protected parameter written");

   a_exc_func: assert property (
      seq_exc_func_byte |=> tx_data_out == ($past(func) | dmdm_pkg::FUNC_EXC_FLAG))
      else $error("exception function byte wrong");

   a_exc_bad_func: assert property (
      seq_exec_taken and (!is_read && !is_write) |=> exc_q == dmdm_pkg::EXC_FUNC)
      else $error("bad function not answered with code 1");

   a_ro_write: assert property (
      seq_exec_taken and (is_write && len_ok &&
      (reg_addr == dmdm_pkg::ADDR_STATUS || reg_addr == dmdm_pkg::ADDR_FAULT))
      |=> rsp == dmdm_pkg::RSP_EXC && exc_q == dmdm_pkg::EXC_ADDR)
      else $error("write to read-only word not refused");

   a_echo_write: assert property (
      seq_exec_taken and write_go |=> rsp == dmdm_pkg::RSP_ECHO && tx_len == 8'h06)
      else $error("successful write not echoed");

   a_answer_start: assert property (
      seq_exec_taken |=> tx_crc == dmdm_pkg::CRC_INIT ##1 tx_valid_out)
      else $error("answer not started from a fresh check value");

endmodule

// ### rtl/dmdm_param_ram.sv
// Parameter storage memory, one port, registered read data.
// Assumes the caller never reads and writes in the same cycle.
`timescale 1ns/1ns
module dmdm_param_ram #(
   parameter int AW = 12,
   parameter int DW = 16
)(
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [DW-1:0] wr_data_in,
   output logic [DW-1:0] rd_data_out
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Array left without reset so it maps onto block memory
   always_ff @(posedge ref_clk_in)
   begin
      if (ce_in && wr_en_in)
         mem[addr_in] <= wr_data_in;
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         rd_data_out <= '0;
      else if (ce_in && rd_en_in)
         rd_data_out <= mem[addr_in];
   end

endmodule

// ### rtl/dmdm_pkg.sv
// Shared constants, types and helpers for the drive data-map command interpreter.
// Assumes a byte-level serial front end on the same clock delivers received bytes.
package dmdm_pkg;

   // ----------------------------------------
   // Register word addresses
   // ----------------------------------------
   localparam logic [15:0] ADDR_FREQ_REF = 16'h1000;
   localparam logic [15:0] ADDR_RUN_CMD = 16'h2000;
   localparam logic [15:0] ADDR_STATUS = 16'h3000;
   localparam logic [15:0] ADDR_FAULT = 16'h8000;

   // ----------------------------------------
   // Parameter groups (high byte of address)
   // ----------------------------------------
   localparam logic [3:0] FAM_LEVEL1_A = 4'hA;
   localparam logic [3:0] FAM_LEVEL1_B = 4'hB;
   localparam logic [3:0] FAM_LEVEL2_E = 4'hE;
   localparam logic [3:0] FAM_LEVEL3_F = 4'hF;
   localparam logic [7:0] MONITOR_GROUP_FIRST = 8'hD0;
   localparam logic [7:0] MONITOR_GROUP_SECOND = 8'hD1;
   localparam logic [7:0] FACTORY_GROUP = 8'hAF;
   localparam logic [3:0] RUN_LOCKED_FAMILY = 4'hB;

   // ----------------------------------------
   // Function and exception codes
   // ----------------------------------------
   localparam logic [7:0] FUNC_READ = 8'h03;
   localparam logic [7:0] FUNC_WRITE = 8'h06;
   localparam logic [7:0] FUNC_EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_DATA = 8'h03;
   localparam logic [7:0] EXC_BUSY = 8'h04;

   // ----------------------------------------
   // Run command values and status bits
   // ----------------------------------------
   localparam logic [15:0] CMD_FWD_RUN = 16'h0001;
   localparam logic [15:0] CMD_REV_RUN = 16'h0002;
   localparam logic [15:0] CMD_COAST_STOP = 16'h0005;
   localparam logic [15:0] CMD_DECEL_STOP = 16'h0006;
   localparam logic [15:0] CMD_FAULT_RESET = 16'h0007;
   localparam logic [15:0] CMD_QUICK_STOP = 16'h0008;
   localparam int STATUS_FWD_BIT = 0;
   localparam int STATUS_REV_BIT = 1;
   localparam int STATUS_FAULT_BIT = 2;
   localparam logic [15:0] FREQ_FULL_SCALE = 16'h2710;

   // ----------------------------------------
   // Frame check and framing
   // ----------------------------------------
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam int MAX_READ_WORDS = 12;
   localparam int FRAME_BUF_BYTES = 8;
   localparam int CLK_PERIOD_NS = 10;
   // One character of 11 bits at 9600 baud; gap is 3.5 characters
   localparam int CHAR_TIME_NS = 1145834;
   localparam int FRAME_GAP_NS = (CHAR_TIME_NS * 7 + 1) / 2;
   localparam int FRAME_GAP_CYCLES = (FRAME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {ST_RX, ST_EXEC, ST_FETCH, ST_PREP, ST_SEND} dmdm_state_e;
   typedef enum logic [1:0] {RSP_ECHO, RSP_EXC, RSP_READ} dmdm_rsp_e;

   function automatic logic [15:0] crc16_byte(input logic [15:0] crc_in,
                                              input logic [7:0] data_in);
      logic [15:0] c;
      c = crc_in ^ {8'h00, data_in};
      for (int b = 0; b < 8; b++)
      begin
         if (c[0])
            c = (c >> 1) ^ CRC_POLY;
         else
            c = c >> 1;
      end
      return c;
   endfunction

   function automatic logic is_param_group(input logic [7:0] hi);
      return (hi[7:4] == FAM_LEVEL1_A) || (hi[7:4] == FAM_LEVEL1_B) ||
             (hi[7:4] == FAM_LEVEL2_E) || (hi[7:4] == FAM_LEVEL3_F) ||
             (hi == MONITOR_GROUP_FIRST) || (hi == MONITOR_GROUP_SECOND);
   endfunction

endpackage
